// ==== include/tmr8_cmp_if.sv ====
// tmr8_cmp_if: signals between the counter core and one compare unit
// assumes a single clock domain shared by both ends
`timescale 1ns/10ps
interface tmr8_cmp_if;
   logic [7:0] count;
   logic [2:0] wgm;
   logic       tick;
   logic       top;
   logic       bottom;
   logic       up;
   logic       block;
   logic       buf_en;
   logic       wr;
   logic [7:0] wdata;
   logic       force_stb;
   logic [1:0] com;
   logic [7:0] ocr;
   logic [7:0] rdata;
   logic       match;
   logic       oc;
   modport core (output count, wgm, tick, top, bottom, up, block, buf_en,
                 wr, wdata, force_stb, com,
                 input ocr, rdata, match, oc);
   modport unit (input count, wgm, tick, top, bottom, up, block, buf_en,
                 wr, wdata, force_stb, com,
                 output ocr, rdata, match, oc);
endinterface : tmr8_cmp_if

// ==== include/tmr8_pkg.sv ====
// tmr8_pkg: constants for the 8-bit timer counter and compare units
// assumes nothing beyond a SystemVerilog compiler
package tmr8_pkg;
   localparam logic [7:0] TMR8_BOTTOM    = 8'h00;
   localparam logic [7:0] TMR8_MAX       = 8'hFF;
   localparam logic [7:0] TMR8_CNT_RST   = 8'h00;
   localparam logic [7:0] TMR8_OCR_RST   = 8'h00;
   localparam logic [2:0] TMR8_CS_STOP   = 3'h0;
   localparam logic [1:0] TMR8_COM_NONE  = 2'h0;
   localparam logic [1:0] TMR8_COM_TOG   = 2'h1;
   localparam logic [1:0] TMR8_COM_CLR   = 2'h2;
   localparam logic [1:0] TMR8_COM_SET   = 2'h3;
   // waveform generation mode codes
   localparam logic [2:0] TMR8_WGM_NORMAL   = 3'h0;
   localparam logic [2:0] TMR8_WGM_PC_MAX   = 3'h1;
   localparam logic [2:0] TMR8_WGM_CTC      = 3'h2;
   localparam logic [2:0] TMR8_WGM_FAST_MAX = 3'h3;
   localparam logic [2:0] TMR8_WGM_PC_OCRA  = 3'h5;
   localparam logic [2:0] TMR8_WGM_FAST_OCRA = 3'h7;
   // prescaler divisions selected by clock_source_select 2..5
   localparam int TMR8_DIV8    = 8;
   localparam int TMR8_DIV64   = 64;
   localparam int TMR8_DIV256  = 256;
   localparam int TMR8_DIV1024 = 1024;
   localparam int TMR8_PRE_W   = 10;
endpackage : tmr8_pkg

// ==== src/tmr8_cmp_unit.sv ====
// tmr8_cmp_unit: one compare unit with buffered compare value and output state
// assumes the core drives tick, top, bottom and block on the same clock
`timescale 1ns/10ps
module tmr8_cmp_unit
   import tmr8_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // core side
   tmr8_cmp_if.unit cmp
);
   logic [7:0] ocr_q;
   logic [7:0] buf_q;
   logic       oc_q;
   logic       eq;
   logic       pwm;
   logic       fire;
   logic       upd;

   assign pwm = cmp.buf_en;
   assign eq  = (cmp.count == ocr_q);
   assign cmp.match = eq & ~cmp.block;
   assign cmp.ocr   = ocr_q;
   assign cmp.rdata = pwm ? buf_q : ocr_q;
   assign cmp.oc    = oc_q;

   // buffered value moves at top in fast pwm, at bottom in phase correct
   assign upd = cmp.tick & ((cmp.wgm[0] & cmp.wgm[1]) ? cmp.top
                                                      : cmp.bottom);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buf_q <= TMR8_OCR_RST;
      end else if (cmp.wr) begin
         buf_q <= cmp.wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ocr_q <= TMR8_OCR_RST;
      end else if (!pwm && cmp.wr) begin
         ocr_q <= cmp.wdata;
      end else if (pwm && upd) begin
         ocr_q <= buf_q;
      end
   end

   // waveform action; com read live, never buffered
   assign fire = (cmp.tick & cmp.match) | (~pwm & cmp.force_stb);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oc_q <= 1'b0;
      end else if (!pwm) begin
         if (fire) begin
            unique case (cmp.com)
               TMR8_COM_NONE: oc_q <= oc_q;
               TMR8_COM_TOG:  oc_q <= ~oc_q;
               TMR8_COM_CLR:  oc_q <= 1'b0;
               TMR8_COM_SET:  oc_q <= 1'b1;
            endcase
         end
      end else if (cmp.tick && cmp.com[1]) begin
         // pwm: non-inverted clears on match counting up, sets on the tick at bottom in fast pwm and on match counting down in phase correct
         if (cmp.match) begin
            oc_q <= cmp.up ? cmp.com[0] : ~cmp.com[0];
         end else if (cmp.wgm[1] && cmp.bottom) begin
            oc_q <= ~cmp.com[0];
         end
      end
      // mode change alone never touches oc_q
   end
endmodule : tmr8_cmp_unit

// ==== src/tmr8_timer.sv ====
// tmr8_timer: 8-bit timer counter unit with two compare units
// assumes control inputs come from cpu logic on CLK; T0 pin is asynchronous
`timescale 1ns/10ps
module tmr8_timer
   import tmr8_pkg::*;
(
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   // control register a and b fields
   input  wire logic [1:0] WAVEFORM_MODE_BIT10,
   input  wire logic       WAVEFORM_MODE_BIT2,
   input  wire logic [2:0] CLOCK_SOURCE_SELECT,
   input  wire logic [1:0] MATCH_OUTPUT_ACTION_A,
   input  wire logic [1:0] MATCH_OUTPUT_ACTION_B,
   input  wire logic       FORCE_MATCH_STROBE_A,
   input  wire logic       FORCE_MATCH_STROBE_B,
   // external count pin
   input  wire logic       T0_PIN,
   // counter access
   input  wire logic       COUNTER_WR,
   input  wire logic [7:0] COUNTER_WDATA,
   output      logic [7:0] COUNTER_VALUE,
   // compare value access
   input  wire logic       COMPARE_A_WR,
   input  wire logic       COMPARE_B_WR,
   input  wire logic [7:0] COMPARE_WDATA,
   output      logic [7:0] COMPARE_VALUE_A,
   output      logic [7:0] COMPARE_VALUE_B,
   // flags: write one to clear, ack on interrupt service
   input  wire logic [2:0] FLAG_CLEAR,
   input  wire logic [2:0] INT_ENABLE,
   input  wire logic [2:0] INT_ACK,
   output      logic       OVERFLOW_FLAG,
   output      logic       MATCH_FLAG_A,
   output      logic       MATCH_FLAG_B,
   output      logic [2:0] INT_REQ,
   // waveform outputs
   output      logic       WAVEFORM_OUTPUT_A,
   output      logic       WAVEFORM_OUTPUT_B
);
   tmr8_cmp_if cia ();
   tmr8_cmp_if cib ();

   logic [7:0]          cnt_q;
   logic                up_q;
   logic                block_q;
   logic [TMR8_PRE_W-1:0] pre_q;
   logic [2:0]          t0_sync_q;
   logic                tick;
   logic [2:0]          wgm;
   logic                pwm;
   logic                pc_mode;
   logic [7:0]          top_val;
   logic                at_top;
   logic                at_bottom;
   logic [2:0]          flag_q;
   logic [2:0]          flag_set;
   logic [2:0]          flag_clr;
   logic [7:0]          cnt_d;

   function automatic logic pre_hit(input logic [TMR8_PRE_W-1:0] p, input int div);
      pre_hit = (p & TMR8_PRE_W'(div - 1)) == '0;
   endfunction : pre_hit

   assign wgm     = {WAVEFORM_MODE_BIT2, WAVEFORM_MODE_BIT10};
   assign pwm     = wgm[0];
   assign pc_mode = wgm[0] & ~wgm[1];
   assign top_val = (wgm == TMR8_WGM_CTC || wgm[2]) ? cia.ocr : TMR8_MAX;
   assign at_top    = (cnt_q == top_val);
   assign at_bottom = (cnt_q == TMR8_BOTTOM);

   // prescaler and external pin, two stages before the edge detector
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         t0_sync_q <= 3'h0;
      end else begin
         t0_sync_q <= {t0_sync_q[1:0], T0_PIN};
      end
   end

   always_comb begin
      unique case (CLOCK_SOURCE_SELECT)
         TMR8_CS_STOP: tick = 1'b0;
         3'h1:         tick = 1'b1;
         3'h2:         tick = pre_hit(pre_q, TMR8_DIV8);
         3'h3:         tick = pre_hit(pre_q, TMR8_DIV64);
         3'h4:         tick = pre_hit(pre_q, TMR8_DIV256);
         3'h5:         tick = pre_hit(pre_q, TMR8_DIV1024);
         3'h6:         tick = t0_sync_q[2] & ~t0_sync_q[1];
         3'h7:         tick = ~t0_sync_q[2] & t0_sync_q[1];
      endcase
   end

   // counter next value
   always_comb begin
      cnt_d = cnt_q;
      if (tick) begin
         if (pc_mode) begin
            cnt_d = (up_q && !at_top) || (!up_q && at_bottom) ? cnt_q + 8'h01
                                                               : cnt_q - 8'h01;
         end else if (at_top && wgm != TMR8_WGM_NORMAL) begin
            cnt_d = TMR8_BOTTOM;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cnt_q <= TMR8_CNT_RST;
      end else if (COUNTER_WR) begin
         cnt_q <= COUNTER_WDATA;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         up_q <= 1'b1;
      end else if (!pc_mode) begin
         up_q <= 1'b1;
      end else if (tick && !COUNTER_WR) begin
         if (at_top) begin
            up_q <= 1'b0;
         end else if (at_bottom) begin
            up_q <= 1'b1;
         end
      end
   end

   // block holds from a counter write until the next tick is consumed
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         block_q <= 1'b0;
      end else if (COUNTER_WR) begin
         block_q <= 1'b1;
      end else if (tick) begin
         block_q <= 1'b0;
      end
   end

   // flags: set on tick at match or overflow; set wins over clear
   // a counter write overrides the wrap, so no overflow on that tick
   assign flag_set[0] = tick & ~COUNTER_WR & (pc_mode ? (at_bottom & ~up_q)
                        : ((wgm != TMR8_WGM_CTC) & (cnt_d == TMR8_BOTTOM)));
   assign flag_set[1] = tick & cia.match;
   assign flag_set[2] = tick & cib.match;
   assign flag_clr    = FLAG_CLEAR | INT_ACK;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         flag_q <= 3'h0;
      end else begin
         flag_q <= (flag_q & ~flag_clr) | flag_set;
      end
   end

   // compare unit connections
   assign cia.count     = cnt_q;
   assign cia.wgm       = wgm;
   assign cia.tick      = tick;
   assign cia.top       = at_top;
   assign cia.bottom    = at_bottom;
   assign cia.up        = up_q;
   assign cia.block     = block_q;
   assign cia.buf_en    = pwm;
   assign cia.wr        = COMPARE_A_WR;
   assign cia.wdata     = COMPARE_WDATA;
   assign cia.force_stb = FORCE_MATCH_STROBE_A;
   assign cia.com       = MATCH_OUTPUT_ACTION_A;
   assign cib.count     = cnt_q;
   assign cib.wgm       = wgm;
   assign cib.tick      = tick;
   assign cib.top       = at_top;
   assign cib.bottom    = at_bottom;
   assign cib.up        = up_q;
   assign cib.block     = block_q;
   assign cib.buf_en    = pwm;
   assign cib.wr        = COMPARE_B_WR;
   assign cib.wdata     = COMPARE_WDATA;
   assign cib.force_stb = FORCE_MATCH_STROBE_B;
   assign cib.com       = MATCH_OUTPUT_ACTION_B;

   tmr8_cmp_unit u_cmp_a (
      .clk (CLK),
      .rst (SYS_RST),
      .cmp (cia)
   );

   tmr8_cmp_unit u_cmp_b (
      .clk (CLK),
      .rst (SYS_RST),
      .cmp (cib)
   );

   assign COUNTER_VALUE     = cnt_q;
   assign COMPARE_VALUE_A   = cia.rdata;
   assign COMPARE_VALUE_B   = cib.rdata;
   assign OVERFLOW_FLAG     = flag_q[0];
   assign MATCH_FLAG_A      = flag_q[1];
   assign MATCH_FLAG_B      = flag_q[2];
   assign INT_REQ           = flag_q & INT_ENABLE;
   assign WAVEFORM_OUTPUT_A = cia.oc;
   assign WAVEFORM_OUTPUT_B = cib.oc;
endmodule : tmr8_timer

// ==== testbench/tmr8_timer_props.sv ====
// tmr8_timer_props: port-level assertions for the 8-bit timer
// assumes it is bound to tmr8_timer, single clock domain
`timescale 1ns/10ps
module tmr8_timer_props
   import tmr8_pkg::*;
(
   // clock and reset
   input wire logic       CLK,
   input wire logic       SYS_RST,
   // controls
   input wire logic [1:0] WAVEFORM_MODE_BIT10,
   input wire logic       WAVEFORM_MODE_BIT2,
   input wire logic [2:0] CLOCK_SOURCE_SELECT,
   input wire logic [1:0] MATCH_OUTPUT_ACTION_A,
   input wire logic       FORCE_MATCH_STROBE_A,
   // counter and compare
   input wire logic       COUNTER_WR,
   input wire logic [7:0] COUNTER_WDATA,
   input wire logic [7:0] COUNTER_VALUE,
   input wire logic       COMPARE_A_WR,
   input wire logic [7:0] COMPARE_VALUE_A,
   // flags and outputs
   input wire logic [2:0] FLAG_CLEAR,
   input wire logic [2:0] INT_ENABLE,
   input wire logic [2:0] INT_ACK,
   input wire logic       OVERFLOW_FLAG,
   input wire logic       MATCH_FLAG_A,
   input wire logic       MATCH_FLAG_B,
   input wire logic [2:0] INT_REQ,
   input wire logic       WAVEFORM_OUTPUT_A
);
   wire logic [2:0] wgm = {WAVEFORM_MODE_BIT2, WAVEFORM_MODE_BIT10};
   wire logic       cs1 = CLOCK_SOURCE_SELECT == 3'h1;
   wire logic       stp = CLOCK_SOURCE_SELECT == TMR8_CS_STOP;
   wire logic       nrm = wgm == TMR8_WGM_NORMAL;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // two back-to-back ticks, the second in normal mode, no counter write
   sequence s_tick;
      (cs1 && !COUNTER_WR) ##1 (cs1 && !COUNTER_WR && nrm);
   endsequence
   sequence s_wr_eq;
      COUNTER_WR && COUNTER_WDATA == COMPARE_VALUE_A && !COMPARE_A_WR && nrm;
   endsequence
   a_stop_holds: assert property (stp && !COUNTER_WR |=> $stable(COUNTER_VALUE))
      else $error("counter moved while stopped");
   a_write_wins: assert property (COUNTER_WR |=> COUNTER_VALUE == $past(COUNTER_WDATA))
      else $error("counter write not applied");
   a_count_up: assert property (s_tick |=> COUNTER_VALUE == $past(COUNTER_VALUE) + 8'h01)
      else $error("counter did not step by one");
   a_ovf_wrap: assert property (s_tick ##0 COUNTER_VALUE == TMR8_MAX |=> OVERFLOW_FLAG)
      else $error("overflow flag missing at wrap");
   a_flag_set: assert property (s_tick ##0 COUNTER_VALUE == COMPARE_VALUE_A |=> MATCH_FLAG_A)
      else $error("match flag not set after tick");
   a_block_match: assert property (s_wr_eq ##1 (cs1 && !MATCH_FLAG_A) |=> !MATCH_FLAG_A)
      else $error("match not blocked after counter write");
   a_flag_hold: assert property (MATCH_FLAG_A && !FLAG_CLEAR[1] && !INT_ACK[1] |=> MATCH_FLAG_A)
      else $error("match flag lost without clear");
   a_flag_clear: assert property (MATCH_FLAG_A && FLAG_CLEAR[1] && stp |=> !MATCH_FLAG_A)
      else $error("match flag not cleared by write");
   a_ack_clear: assert property (MATCH_FLAG_B && INT_ACK[2] && stp |=> !MATCH_FLAG_B)
      else $error("flag not cleared on service");
   a_int_req: assert property (INT_REQ == ({MATCH_FLAG_B, MATCH_FLAG_A, OVERFLOW_FLAG} & INT_ENABLE))
      else $error("interrupt request mismatch");
   a_force_quiet: assert property (FORCE_MATCH_STROBE_A && !MATCH_FLAG_A && stp && !COUNTER_WR
      |=> !MATCH_FLAG_A && $stable(COUNTER_VALUE))
      else $error("force changed flag or counter");
   a_force_level: assert property (FORCE_MATCH_STROBE_A && !wgm[0] && stp && MATCH_OUTPUT_ACTION_A[1]
      |=> WAVEFORM_OUTPUT_A == $past(MATCH_OUTPUT_ACTION_A[0]))
      else $error("forced set or clear wrong");
   a_force_tog: assert property (FORCE_MATCH_STROBE_A && !wgm[0] && stp
      && MATCH_OUTPUT_ACTION_A == TMR8_COM_TOG |=> $changed(WAVEFORM_OUTPUT_A))
      else $error("forced toggle missing");
endmodule : tmr8_timer_props

bind tmr8_timer tmr8_timer_props tmr8_timer_props_inst (.CLK(CLK), .SYS_RST(SYS_RST),
   .WAVEFORM_MODE_BIT10(WAVEFORM_MODE_BIT10), .WAVEFORM_MODE_BIT2(WAVEFORM_MODE_BIT2),
   .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .MATCH_OUTPUT_ACTION_A(MATCH_OUTPUT_ACTION_A),
   .FORCE_MATCH_STROBE_A(FORCE_MATCH_STROBE_A), .COUNTER_WR(COUNTER_WR),
   .COUNTER_WDATA(COUNTER_WDATA), .COUNTER_VALUE(COUNTER_VALUE), .COMPARE_A_WR(COMPARE_A_WR),
   .COMPARE_VALUE_A(COMPARE_VALUE_A), .FLAG_CLEAR(FLAG_CLEAR), .INT_ENABLE(INT_ENABLE),
   .INT_ACK(INT_ACK), .OVERFLOW_FLAG(OVERFLOW_FLAG), .MATCH_FLAG_A(MATCH_FLAG_A),
   .MATCH_FLAG_B(MATCH_FLAG_B), .INT_REQ(INT_REQ), .WAVEFORM_OUTPUT_A(WAVEFORM_OUTPUT_A));

// ==== testbench/tmr8_timer_tb.sv ====
// tmr8_timer_tb: self-checking bench for the 8-bit timer
// assumes the port checker is bound from its own file
`timescale 1ns/10ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, a); end end
module tmr8_timer_tb
   import tmr8_pkg::*;
;
   logic       clk, rst, wgm2, foca, focb, t0, cwr, cawr, cbwr, p;
   logic [1:0] wgm10, coma, comb;
   logic [2:0] cs, fclr, ien, iack, ireq;
   logic [7:0] cwd, cwdat, cnt, cva, cvb, v;
   logic       ovf, mfa, mfb, woa, wob;
   integer     seed, bad_count, num_checks, i, n;

   tmr8_timer tmr8_timer_inst (.CLK(clk), .SYS_RST(rst), .WAVEFORM_MODE_BIT10(wgm10),
      .WAVEFORM_MODE_BIT2(wgm2), .CLOCK_SOURCE_SELECT(cs), .MATCH_OUTPUT_ACTION_A(coma),
      .MATCH_OUTPUT_ACTION_B(comb), .FORCE_MATCH_STROBE_A(foca), .FORCE_MATCH_STROBE_B(focb),
      .T0_PIN(t0), .COUNTER_WR(cwr), .COUNTER_WDATA(cwd), .COUNTER_VALUE(cnt),
      .COMPARE_A_WR(cawr), .COMPARE_B_WR(cbwr), .COMPARE_WDATA(cwdat), .COMPARE_VALUE_A(cva),
      .COMPARE_VALUE_B(cvb), .FLAG_CLEAR(fclr), .INT_ENABLE(ien), .INT_ACK(iack),
      .OVERFLOW_FLAG(ovf), .MATCH_FLAG_A(mfa), .MATCH_FLAG_B(mfb), .INT_REQ(ireq),
      .WAVEFORM_OUTPUT_A(woa), .WAVEFORM_OUTPUT_B(wob));

   always #5 clk = ~clk;

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   task automatic wr_cnt(input logic [7:0] d);
      @(posedge clk);
      cwr <= 1'b1;
      cwd <= d;
      @(posedge clk);
      cwr <= 1'b0;
   endtask : wr_cnt

   task automatic wr_cmp(input logic [7:0] d);
      @(posedge clk);
      {cawr, cbwr} <= 2'h3;
      cwdat <= d;
      @(posedge clk);
      {cawr, cbwr} <= 2'h0;
   endtask : wr_cmp

   // k consecutive ticks at full rate
   task automatic run(input integer k);
      @(posedge clk);
      cs <= 3'h1;
      repeat (k) @(posedge clk);
      cs <= 3'h0;
   endtask : run

   task automatic flags(input logic [2:0] c, input logic [2:0] a);
      @(posedge clk);
      fclr <= c;
      iack <= a;
      @(posedge clk);
      fclr <= 3'h0;
      iack <= 3'h0;
   endtask : flags

   function automatic logic fexp(input logic [1:0] c, input logic q);
      case (c)
         TMR8_COM_TOG: fexp = ~q;
         TMR8_COM_CLR: fexp = 1'b0;
         TMR8_COM_SET: fexp = 1'b1;
         default: fexp = q;
      endcase
   endfunction : fexp

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out;
   end

   initial begin
      {clk, wgm2, foca, focb, t0, cwr, cawr, cbwr, wgm10, coma, comb} = '0;
      {cs, fclr, iack, cwd, cwdat} = '0;
      rst = 1'b1;
      ien = 3'h7;
      seed = 71;
      bad_count = 0;
      num_checks = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("out a", 1'b0, woa)
      for (i = 3; i >= 1; i--) begin
         p = woa;
         @(posedge clk);
         coma <= 2'(i);
         foca <= 1'b1;
         @(posedge clk);
         foca <= 1'b0;
         @(negedge clk);
         `CHK("forced out", fexp(2'(i), p), woa)
         `CHK("force flag", 1'b0, mfa)
         `CHK("force count", 8'h00, cnt)
      end
      @(posedge clk);
      wgm10 <= TMR8_WGM_PC_MAX[1:0];
      @(posedge clk);
      wgm10 <= TMR8_WGM_NORMAL[1:0];
      @(negedge clk);
      `CHK("kept out", 1'b1, woa)
      v = 8'($random(seed));
      wr_cnt(v);
      @(negedge clk);
      `CHK("cnt write", v, cnt)
      n = 1 + {$random(seed)} % 20;
      run(n);
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("cnt run", 8'(v + 8'(n)), cnt)
      wr_cnt(8'h00);
      flags(3'h7, 3'h0);
      for (i = 0; i < 4; i++) begin
         // even, so never equal to the odd count left by the last pass
         v = 8'(8 + 2 * ({$random(seed)} % 120));
         wr_cmp(v);
         @(negedge clk);
         `CHK("cmp a", v, cva)
         `CHK("cmp b", v, cvb)
         @(posedge clk);
         {cwr, cs} <= {1'b1, 3'h1};
         cwd <= v;
         @(posedge clk);
         cwr <= 1'b0;
         @(posedge clk);
         cs <= 3'h0;
         @(negedge clk);
         `CHK("blocked", 1'b0, mfa)
         `CHK("cnt beat", 8'(v + 8'h01), cnt)
         wr_cnt(v - 8'h04);
         run(3);
         @(negedge clk);
         `CHK("early flag", 1'b0, mfa)
         p = woa;
         run(2);
         @(negedge clk);
         `CHK("flag a", 1'b1, mfa)
         `CHK("flag b", 1'b1, mfb)
         `CHK("int req", 3'h6, ireq)
         flags(3'h2, 3'h4);
         @(negedge clk);
         `CHK("flags clr", 2'h0, {mfb, mfa})
         `CHK("toggled", ~p, woa)
      end
      wr_cnt(8'hFD);
      run(3);
      @(negedge clk);
      `CHK("ovf", 1'b1, ovf)
      `CHK("ovf req", 3'h1, ireq)
      flags(3'h0, 3'h1);
      @(negedge clk);
      `CHK("ovf ack", 1'b0, ovf)
      @(posedge clk);
      wgm10 <= TMR8_WGM_CTC[1:0];
      wr_cmp(8'h05);
      wr_cnt(8'h00);
      n = 1 + {$random(seed)} % 20;
      run(n);
      @(negedge clk);
      `CHK("ctc cnt", 8'(n % 6), cnt)
      @(posedge clk);
      wgm10 <= TMR8_WGM_FAST_MAX[1:0];
      v = 8'($random(seed));
      wr_cmp(v);
      @(negedge clk);
      `CHK("buf a", v, cva)
      // fast pwm with compare a as top; buffers load at top
      @(posedge clk);
      {wgm2, comb} <= {1'b1, TMR8_COM_SET};
      wr_cmp(8'h09);
      wr_cnt(8'h00);
      run(6);
      @(negedge clk);
      `CHK("top a", 8'h00, cnt)
      `CHK("pwm ovf", 1'b1, ovf)
      `CHK("pwm b set", 1'b1, wob)
      run(6);
      @(negedge clk);
      `CHK("top moved", 8'h06, cnt)
      `CHK("pwm b clr", 1'b0, wob)
      // prescaled ticks, then rising edges of the count pin
      @(posedge clk);
      {wgm2, wgm10} <= {1'b0, TMR8_WGM_NORMAL[1:0]};
      wr_cnt(8'h00);
      @(posedge clk);
      cs <= 3'h2;
      repeat (64) @(posedge clk);
      cs <= 3'h7;
      n = 1 + {$random(seed)} % 9;
      repeat (n) begin
         repeat (3) @(posedge clk);
         t0 <= 1'b1;
         repeat (3) @(posedge clk);
         t0 <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs <= 3'h0;
      @(negedge clk);
      `CHK("ext count", 8'(64 / TMR8_DIV8 + n), cnt)
      close_out;
   end
endmodule : tmr8_timer_tb
